// ### design/acs_ch0_route.sv
// routing decoder for channel 0 of one sample set
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_ch0_route
(
   // stored selections
   input wire logic [4:0] pos_sel,
   input wire logic neg_sel,
   input wire logic [2:0] opamp_route_enable,
   // decoded sources
   output logic [4:0] pos_src,
   output logic [4:0] neg_src,
   output logic reserved
);
   wire logic is_an = (pos_sel[4] == 1'b0);
   wire logic is_oa1 = (pos_sel == `ACS_POS_OA1);
   wire logic is_oa2 = (pos_sel == `ACS_POS_OA2);
   wire logic is_oa3 = (pos_sel == `ACS_POS_OA3);
   wire logic is_temp = (pos_sel == `ACS_POS_TEMP);
   wire logic is_open = (pos_sel == `ACS_POS_OPEN);

   // an op amp code with the amp off routes the shared analog pin
   assign pos_src = is_an ? pos_sel :
                    is_oa1 ? (opamp_route_enable[0] ? acs_pkg::acs_src_oa1
                                                    : acs_pkg::acs_src_an3) :
                    is_oa2 ? (opamp_route_enable[1] ? acs_pkg::acs_src_oa2
                                                    : acs_pkg::acs_src_an0) :
                    is_oa3 ? (opamp_route_enable[2] ? acs_pkg::acs_src_oa3
                                                    : acs_pkg::acs_src_an6) :
                    is_temp ? acs_pkg::acs_src_temp :
                    acs_pkg::acs_src_open; // reserved codes also leave it open
   assign reserved = !(is_an || is_oa1 || is_oa2 || is_oa3 || is_temp || is_open);
   assign neg_src = neg_sel ? acs_pkg::acs_src_an1 : acs_pkg::acs_src_vrefl;
endmodule // acs_ch0_route

// ### design/acs_consts.svh
// register offsets, field positions, reset values and routing codes for the input select block
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_OFF_CH123      5'h00
`define ACS_OFF_CH0        5'h04
`define ACS_OFF_SCAN_HI    5'h08
`define ACS_OFF_SCAN_LO    5'h0C
`define ACS_OFF_CTRL       5'h10

`define ACS_CH123_MASK     16'h0707
`define ACS_CH0_MASK       16'h9F9F
`define ACS_SCAN_HI_MASK   16'hC700
`define ACS_SCAN_LO_MASK   16'hFFFF
`define ACS_CTRL_MASK      16'h001F
`define ACS_RESET_VAL      16'h0000

`define ACS_POS_OA1        5'h18
`define ACS_POS_OA2        5'h19
`define ACS_POS_OA3        5'h1A
`define ACS_POS_TEMP       5'h1C
`define ACS_POS_OPEN       5'h1F

`define ACS_NEG_HIGH       2'h3
`define ACS_NEG_MID        2'h2

`define ACS_SCAN_OPEN_BIT  15
`define ACS_SCAN_TEMP_BIT  14
`define ACS_SCAN_OA3_BIT   10
`define ACS_SCAN_OA2_BIT   9
`define ACS_SCAN_OA1_BIT   8

`endif

// ### design/acs_grp_route.sv
// routing decoder for channels 1 to 3 of one sample set
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_grp_route
(
   // stored selections
   input wire logic pos_sel,
   input wire logic [1:0] neg_sel,
   input wire logic [2:0] opamp_route_enable,
   // decoded sources for channels 1, 2, 3
   output logic [4:0] pos_src [3],
   output logic [4:0] neg_src [3]
);
   // shared pins fall back to the plain analog pin when the op amp is off
   function automatic logic [4:0] shared(input logic en, input logic [4:0] oa,
                                         input logic [4:0] an);
      shared = en ? oa : an;
   endfunction

   // positive: two-way routing, identical for both sample sets
   assign pos_src[0] = pos_sel ? shared(opamp_route_enable[0], acs_pkg::acs_src_oa1,
                                        acs_pkg::acs_src_an3)
                               : shared(opamp_route_enable[1], acs_pkg::acs_src_oa2,
                                        acs_pkg::acs_src_an0);
   assign pos_src[1] = pos_sel ? shared(opamp_route_enable[1], acs_pkg::acs_src_oa2,
                                        acs_pkg::acs_src_an0)
                               : acs_pkg::acs_src_an1;
   assign pos_src[2] = pos_sel ? shared(opamp_route_enable[2], acs_pkg::acs_src_oa3,
                                        acs_pkg::acs_src_an6)
                               : acs_pkg::acs_src_an2;

   wire logic neg_hi = (neg_sel == `ACS_NEG_HIGH);
   wire logic neg_mid = (neg_sel == `ACS_NEG_MID);

   // negative: codes 0x fall to the low reference
   assign neg_src[0] = neg_hi ? acs_pkg::acs_src_an9 :
                       neg_mid ? shared(opamp_route_enable[2], acs_pkg::acs_src_oa3,
                                        acs_pkg::acs_src_an6)
                               : acs_pkg::acs_src_vrefl;
   assign neg_src[1] = neg_hi ? acs_pkg::acs_src_an10 :
                       neg_mid ? acs_pkg::acs_src_an7 : acs_pkg::acs_src_vrefl;
   assign neg_src[2] = neg_hi ? acs_pkg::acs_src_an11 :
                       neg_mid ? acs_pkg::acs_src_an8 : acs_pkg::acs_src_vrefl;
endmodule // acs_grp_route

// ### design/acs_input_select.sv
// converter input select registers with AXI4-Lite slave and mux drive
`timescale 1ns/100ps
`include "acs_consts.svh"
// What this block does
// - group negative A: 11, 10, 0x routing
// - group positive B: two-way op amp routing
// - group positive A matches group B routing
// - 12-bit mode: group fields read zero
// - shared pin routes op amp when enabled
// - channel 0 positive A five-bit code map
// - code 11100 selects temperature diode
// - high scan bits include open, temp, op amps
// - low scan bit x includes input x
// - absent scan inputs convert the low reference
// - op amps scanned via high scan bits 8, 9, 10
// - unimplemented bits ignore writes, read zero
// - alternate option toggles sets A and B
module acs_input_select
#(
   parameter logic [15:0] PRESENT_INPUTS = 16'hFFFF
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter sample timing
   input wire logic sample_done,
   // multiplexer select lines, live set, reserved flag and scan masks
   output logic [4:0] ch0_pos_src,
   output logic [4:0] ch0_neg_src,
   output logic [14:0] grp_pos_src,
   output logic [14:0] grp_neg_src,
   output logic using_set_b,
   output logic ch0_reserved,
   output logic [31:0] scan_include_mask,
   output logic [31:0] scan_converts_vrefl
);
   logic [15:0] ch123_input_select;
   logic [15:0] ch0_input_select;
   logic [15:0] scan_select_high;
   logic [15:0] scan_select_low;
   logic [15:0] control; // [4] alternate, [3] wide mode, [2:0] op amp enables
   logic set_b;
   logic [4:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic [31:0] next_rdata;

   // merge byte lanes and clear unimplemented positions
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      if (s[0])
         v[7:0] = d[7:0];
      if (s[1])
         v[15:8] = d[15:8];
      merge = v & m;
   endfunction

   wire logic wide_single_sample_mode = control[3];
   wire logic alternate_sample_option = control[4];
   wire logic [2:0] opamp_route_enable = control[2:0];

   // write side: address and data taken independently, in either order
   wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
   wire logic wr_ch123 = wr_fire && (aw_addr == `ACS_OFF_CH123);
   wire logic wr_ch0 = wr_fire && (aw_addr == `ACS_OFF_CH0);
   wire logic wr_hi = wr_fire && (aw_addr == `ACS_OFF_SCAN_HI);
   wire logic wr_lo = wr_fire && (aw_addr == `ACS_OFF_SCAN_LO);
   wire logic wr_ctl = wr_fire && (aw_addr == `ACS_OFF_CTRL);
   wire logic wr_hit = wr_ch123 || wr_ch0 || wr_hi || wr_lo || wr_ctl;
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 5'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2; // unmapped answers slverr
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // register file; group fields cannot be written in 12-bit mode
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ch123_input_select <= `ACS_RESET_VAL;
         ch0_input_select <= `ACS_RESET_VAL;
         scan_select_high <= `ACS_RESET_VAL;
         scan_select_low <= `ACS_RESET_VAL;
         control <= `ACS_RESET_VAL;
      end
      else
      begin
         if (wr_ch123 && !wide_single_sample_mode)
            ch123_input_select <= merge(ch123_input_select, w_data, w_strb,
                                        `ACS_CH123_MASK);
         if (wr_ch0)
            ch0_input_select <= merge(ch0_input_select, w_data, w_strb,
                                      `ACS_CH0_MASK);
         if (wr_hi)
            scan_select_high <= merge(scan_select_high, w_data, w_strb,
                                      `ACS_SCAN_HI_MASK);
         if (wr_lo)
            scan_select_low <= merge(scan_select_low, w_data, w_strb, `ACS_SCAN_LO_MASK);
         if (wr_ctl)
            control <= merge(control, w_data, w_strb, `ACS_CTRL_MASK);
      end
   end

   // read side: one cycle from address to data
   wire logic [15:0] ch123_view = wide_single_sample_mode ? 16'h0000
                                                          : ch123_input_select;
   wire logic rd_ok = (s_axi_araddr == `ACS_OFF_CH123)
                   || (s_axi_araddr == `ACS_OFF_CH0)
                   || (s_axi_araddr == `ACS_OFF_SCAN_HI)
                   || (s_axi_araddr == `ACS_OFF_SCAN_LO)
                   || (s_axi_araddr == `ACS_OFF_CTRL);
   assign s_axi_arready = !s_axi_rvalid;

   always_comb
   begin
      next_rdata = 32'h00000000;
      unique case (s_axi_araddr)
         `ACS_OFF_CH123: next_rdata = {16'h0000, ch123_view};
         `ACS_OFF_CH0: next_rdata = {16'h0000, ch0_input_select};
         `ACS_OFF_SCAN_HI: next_rdata = {16'h0000, scan_select_high};
         `ACS_OFF_SCAN_LO: next_rdata = {16'h0000, scan_select_low};
         `ACS_OFF_CTRL: next_rdata = {16'h0000, control};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // sample set toggles per completed sample while alternating
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         set_b <= 1'b0;
      else if (!alternate_sample_option)
         set_b <= 1'b0;
      else if (sample_done)
         set_b <= !set_b;
   end
   assign using_set_b = set_b;

   // decoders for both sets; output mux picks the live one
   logic [4:0] ga_pos [3];
   logic [4:0] ga_neg [3];
   logic [4:0] gb_pos [3];
   logic [4:0] gb_neg [3];
   logic [4:0] ca_pos;
   logic [4:0] ca_neg;
   logic [4:0] cb_pos;
   logic [4:0] cb_neg;
   logic ca_res;
   logic cb_res;

   acs_grp_route u_grp_a
   (
      .pos_sel(ch123_view[0]),
      .neg_sel(ch123_view[2:1]),
      .opamp_route_enable(opamp_route_enable),
      .pos_src(ga_pos),
      .neg_src(ga_neg)
   );
   acs_grp_route u_grp_b
   (
      .pos_sel(ch123_view[8]),
      .neg_sel(ch123_view[10:9]),
      .opamp_route_enable(opamp_route_enable),
      .pos_src(gb_pos),
      .neg_src(gb_neg)
   );
   acs_ch0_route u_ch0_a
   (
      .pos_sel(ch0_input_select[4:0]),
      .neg_sel(ch0_input_select[7]),
      .opamp_route_enable(opamp_route_enable),
      .pos_src(ca_pos),
      .neg_src(ca_neg),
      .reserved(ca_res)
   );
   acs_ch0_route u_ch0_b
   (
      .pos_sel(ch0_input_select[12:8]),
      .neg_sel(ch0_input_select[15]),
      .opamp_route_enable(opamp_route_enable),
      .pos_src(cb_pos),
      .neg_src(cb_neg),
      .reserved(cb_res)
   );

   // combinational drive from stored fields, no extra latency
   assign ch0_pos_src = set_b ? cb_pos : ca_pos;
   assign ch0_neg_src = set_b ? cb_neg : ca_neg;
   assign ch0_reserved = set_b ? cb_res : ca_res;
   assign grp_pos_src = set_b ? {gb_pos[2], gb_pos[1], gb_pos[0]}
                              : {ga_pos[2], ga_pos[1], ga_pos[0]};
   assign grp_neg_src = set_b ? {gb_neg[2], gb_neg[1], gb_neg[0]}
                              : {ga_neg[2], ga_neg[1], ga_neg[0]};

   // scan mask: low word is AN0..AN15, high word mirrors the high register
   assign scan_include_mask = {scan_select_high, scan_select_low};
   // selected but absent analog inputs become low reference conversions
   assign scan_converts_vrefl = {16'h0000, scan_select_low & ~PRESENT_INPUTS};

   // hidden group fields must read back as zero while wide mode is on
   wide_mode_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wide_single_sample_mode && s_axi_arvalid && !s_axi_rvalid
         && s_axi_araddr == `ACS_OFF_CH123) |=> s_axi_rdata == 32'h00000000)
      else $error("group fields visible in wide mode");
   alt_off_set_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !alternate_sample_option |=> !using_set_b)
      else $error("set b used with alternation off");
   alt_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (alternate_sample_option && sample_done) |=> using_set_b != $past(using_set_b))
      else $error("sample set did not alternate");
   ch0_reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ch0_input_select & ~`ACS_CH0_MASK) == 16'h0000)
      else $error("channel 0 unimplemented bits set");
   scan_hi_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (scan_select_high & ~`ACS_SCAN_HI_MASK) == 16'h0000)
      else $error("scan high unimplemented bits set");
   temp_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!set_b && ch0_input_select[4:0] == `ACS_POS_TEMP)
         |-> ch0_pos_src == acs_pkg::acs_src_temp)
      else $error("temperature code not routed");
   ch0_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!set_b && !ch0_input_select[7]) |-> ch0_neg_src == acs_pkg::acs_src_vrefl)
      else $error("channel 0 negative a misrouted");
   grp_neg_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!set_b && !ch123_view[2]) |-> grp_neg_src[4:0] == acs_pkg::acs_src_vrefl)
      else $error("group negative 0x not low reference");
   wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && (s_axi_bresp == 2'h2) == !$past(wr_hit))
      else $error("write response mismatch");
endmodule // acs_input_select

// ### design/acs_pkg.sv
// types shared by the input select block
package acs_pkg;
   // analog source codes driven onto the multiplexer select lines
   typedef enum logic [4:0]
   {
      acs_src_an0 = 5'h00,
      acs_src_an1 = 5'h01,
      acs_src_an2 = 5'h02,
      acs_src_an3 = 5'h03,
      acs_src_an6 = 5'h06,
      acs_src_an7 = 5'h07,
      acs_src_an8 = 5'h08,
      acs_src_an9 = 5'h09,
      acs_src_an10 = 5'h0A,
      acs_src_an11 = 5'h0B,
      acs_src_oa1 = 5'h18,
      acs_src_oa2 = 5'h19,
      acs_src_oa3 = 5'h1A,
      acs_src_temp = 5'h1C,
      acs_src_vrefl = 5'h1D,
      acs_src_open = 5'h1F
   } acs_src_e;

   typedef logic [4:0] acs_code_t;
endpackage

// ### testbench/acs_input_select_tb_top.sv
// self-checking bench for the converter input select registers
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_input_select_tb_top;
   // register offsets and the bits each one keeps
   localparam logic [4:0] OFFS [5] = '{`ACS_OFF_CH123, `ACS_OFF_CH0, `ACS_OFF_SCAN_HI,
      `ACS_OFF_SCAN_LO, `ACS_OFF_CTRL};
   localparam logic [15:0] KEEP [5] = '{16'h0707, 16'h9F9F, 16'hC700, 16'hFFFF, 16'h001F};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic sample_done = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, set_b, ch0_res;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, scan_mask, scan_vrefl;
   logic [4:0] ch0_pos, ch0_neg, cv;
   logic [14:0] grp_pos, grp_neg;
   logic [5:0] e;
   logic [2:0] oa;
   int fails = 0, tests_run = 0, cycles = 0;

   // 50 MHz clock
   always #10 aclk = ~aclk;

   // only the low eight inputs exist, so the upper ones convert the low reference when scanned
   acs_input_select #(.PRESENT_INPUTS(16'h00FF)) i_dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sample_done(sample_done),
      .ch0_pos_src(ch0_pos), .ch0_neg_src(ch0_neg), .grp_pos_src(grp_pos),
      .grp_neg_src(grp_neg), .using_set_b(set_b), .ch0_reserved(ch0_res),
      .scan_include_mask(scan_mask), .scan_converts_vrefl(scan_vrefl)
   );

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard: the whole sequence needs well under 3000 cycles
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fails++;
         $display("mismatch at %0t: run timed out", $time);
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // ready and answer are sampled at the falling edge, where they hold for the coming edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] s,
      input logic [1:0] exp_resp);
      logic ta, tw, tb;
      logic [1:0] resp;
      int n;
      n = 0;
      tb = 1'b0;
      resp = 2'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && n < 40)
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bready && bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      chk(tb, 1'b1, "write answered");
      chk(resp, exp_resp, "write response");
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic [1:0] exp_resp);
      logic ta, tr;
      logic [1:0] resp;
      logic [31:0] data;
      int n;
      n = 0;
      tr = 1'b0;
      resp = 2'h0;
      data = 32'h00000000;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && n < 40)
      begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rready && rvalid;
         data = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      chk(tr, 1'b1, "read answered");
      chk(data, {16'h0000, exp}, "read data");
      chk(resp, exp_resp, "read response");
   endtask

   // mux select lines, looked at once settled
   task automatic outs(input logic [4:0] p0, input logic [4:0] n0, input logic [29:0] g,
      input logic sb);
      @(negedge aclk);
      chk(ch0_pos, p0, "ch0 positive");
      chk(ch0_neg, n0, "ch0 negative");
      chk({grp_neg, grp_pos}, g, "group sources");
      chk(set_b, sb, "set b live");
   endtask

   task automatic pulse();
      @(posedge aclk);
      sample_done <= 1'b1;
      @(posedge aclk);
      sample_done <= 1'b0;
   endtask

   // expected group sources {neg ch3..ch1, pos ch3..ch1} for one sample set
   function automatic logic [29:0] exp_grp(input logic p, input logic [1:0] n,
      input logic [2:0] o);
      logic [14:0] ps, ns;
      logic [4:0] a0;
      a0 = o[1] ? 5'h19 : 5'h00;
      if (p)
         ps = {o[2] ? 5'h1A : 5'h06, a0, o[0] ? 5'h18 : 5'h03};
      else
         ps = {5'h02, 5'h01, a0};
      if (n == 2'h3)
         ns = {5'h0B, 5'h0A, 5'h09};
      else if (n == 2'h2)
         ns = {5'h08, 5'h07, o[2] ? 5'h1A : 5'h06};
      else
         ns = {3{5'h1D}};
      return {ns, ps};
   endfunction

   // expected {reserved, source} for a channel 0 positive code
   function automatic logic [5:0] exp_ch0(input logic [4:0] c, input logic [2:0] o);
      if (c < 5'h10)
         return {1'b0, c};
      case (c)
         5'h18: return {1'b0, o[0] ? 5'h18 : 5'h03};
         5'h19: return {1'b0, o[1] ? 5'h19 : 5'h00};
         5'h1A: return {1'b0, o[2] ? 5'h1A : 5'h06};
         5'h1C: return 6'h1C;
         5'h1F: return 6'h1F;
         default: return 6'h3F;
      endcase
   endfunction

   // main sequence
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++)
         rd(OFFS[i], 16'h0000, 2'h0);
      outs(5'h00, 5'h1D, exp_grp(1'b0, 2'h0, 3'h0), 1'b0);
      $display("test reset values done");
      for (int i = 0; i < 5; i++)
      begin
         wr(OFFS[i], 16'hFFFF, 4'h3, 2'h0);
         rd(OFFS[i], KEEP[i], 2'h0);
      end
      rd(`ACS_OFF_CH123, 16'h0000, 2'h0);
      outs(5'h1F, 5'h01, exp_grp(1'b0, 2'h0, 3'h7), 1'b0);
      chk(ch0_res, 1'b0, "open code not reserved");
      chk(scan_mask, 32'hC700FFFF, "scan mask");
      chk(scan_vrefl, 32'h0000FF00, "absent inputs");
      pulse();
      outs(5'h1F, 5'h01, exp_grp(1'b0, 2'h0, 3'h7), 1'b1);
      pulse();
      outs(5'h1F, 5'h01, exp_grp(1'b0, 2'h0, 3'h7), 1'b0);
      wr(`ACS_OFF_CH123, 16'h0000, 4'h3, 2'h0);
      wr(`ACS_OFF_CTRL, 16'h0000, 4'h3, 2'h0);
      rd(`ACS_OFF_CH123, 16'h0707, 2'h0);
      $display("test masks and wide mode done");
      wr(5'h14, 16'hFFFF, 4'h3, 2'h2);
      rd(5'h14, 16'h0000, 2'h2);
      wr(`ACS_OFF_CH0, 16'h0000, 4'h1, 2'h0);
      rd(`ACS_OFF_CH0, 16'h9F00, 2'h0);
      $display("test unmapped and strobes done");
      // every channel 0 code and every group code: op amps off, all on, then mixed
      // the mixed pass catches op amp 2's enable bit swapped with either of the other two
      for (int k = 0; k < 3; k++)
      begin
         oa = (k == 0) ? 3'h0 : ((k == 1) ? 3'h7 : 3'h5);
         wr(`ACS_OFF_CTRL, {13'h0000, oa}, 4'h3, 2'h0);
         for (int c = 0; c < 32; c++)
         begin
            cv = c[4:0];
            e = exp_ch0(cv, oa);
            wr(`ACS_OFF_CH0, {8'h00, cv[0], 2'b00, cv}, 4'h3, 2'h0);
            wr(`ACS_OFF_CH123, {13'h0000, cv[2:0]}, 4'h3, 2'h0);
            outs(e[4:0], cv[0] ? 5'h01 : 5'h1D, exp_grp(cv[0], cv[2:1], oa), 1'b0);
            chk(ch0_res, e[5], "reserved flag");
         end
      end
      $display("test routing tables done");
      // set b fields live only while the alternate option is on
      wr(`ACS_OFF_CTRL, 16'h0010, 4'h3, 2'h0);
      wr(`ACS_OFF_CH123, 16'h0700, 4'h3, 2'h0);
      wr(`ACS_OFF_CH0, 16'h9C05, 4'h3, 2'h0);
      outs(5'h05, 5'h1D, exp_grp(1'b0, 2'h0, 3'h0), 1'b0);
      pulse();
      outs(5'h1C, 5'h01, exp_grp(1'b1, 2'h3, 3'h0), 1'b1);
      wr(`ACS_OFF_CTRL, 16'h0000, 4'h3, 2'h0);
      outs(5'h05, 5'h1D, exp_grp(1'b0, 2'h0, 3'h0), 1'b0);
      $display("test alternate sets done");
      tally_and_finish();
   end
endmodule // acs_input_select_tb_top
